// [hdl/wwd_pkg.sv]
// Purpose: constants, types and helpers of the windowed watchdog with deep fail-safe entry
// Assumes: clk at 125 MHz; one time base tick every 0.5 ms
// Notes: register offsets are byte addresses of aligned 32-bit words
//
// Operation
// RULE1: deep fail-safe on final faults or long reset
// RULE2: deep fail-safe: regulators off, all outputs asserted
// RULE3: key low to off, key high wakes
// RULE4: power-up long-reset timer from preregulator wait to release
// RULE5: long-reset timer disable only during init phase
// RULE6: long-reset timer restarts at each reset assertion
// RULE7: debug mode: counters run, no pin effect; the code still enters deep fail-safe at the final fault count
// RULE8: fifteen window periods, settable in init or normal
// RULE9: watchdog inhibit writable only during init phase
// RULE10: refresh in open window is good, restarts window
// RULE11: closed-window refresh is wrong, counts, restarts window
// RULE12: any written refresh value is accepted
// RULE13: initial 256 ms window fully open
// RULE14: first good refresh ends init; timeout faults
// RULE15: normal mode uses configured period, default 3 ms
// RULE16: new period at refresh/timeout, immediately when inhibited
// RULE17: fixed half closed, half open window split
// RULE18: error counter plus two, minus one, init-set max
// RULE19: refresh counter at limit lowers fault counter
// RULE20: wrong refresh clears refresh counter
// RULE21: open timeout counts as wrong refresh
// RULE22: refresh fault impact selects reset and/or safe output
// RULE23: fault counter plus one per reset/safe assertion
// RULE24: threshold select gives 3/6 or 1/2
// RULE25: all timing from own-clock counters, cleared at reset
package wwd_pkg;

    localparam int CLK_PERIOD_NS = 8;
    localparam int TICK_NS = 500000;
    localparam int TICK_CYC_DEF = TICK_NS / CLK_PERIOD_NS;
    localparam int TICKS_PER_MS = 1000000 / TICK_NS;

    localparam int INIT_WIN_MS = 256;
    localparam int LONG_RESET_MS = 8000;
    localparam int PWRUP_RELEASE_US = 16500;
    localparam int RESET_LOW_MS = 10;

    localparam logic [9:0] INIT_LAST = 10'(INIT_WIN_MS * TICKS_PER_MS - 1);
    localparam logic [14:0] LONG_TICKS = 15'(LONG_RESET_MS * TICKS_PER_MS);
    localparam logic [5:0] PWRUP_LAST = 6'((PWRUP_RELEASE_US * 1000) / TICK_NS - 1);
    localparam logic [5:0] RSTLOW_LAST = 6'(RESET_LOW_MS * TICKS_PER_MS - 1);

    localparam logic [7:0] CFG_OFS = 8'h00;
    localparam logic [7:0] WIN_OFS = 8'h04;
    localparam logic [7:0] REF_OFS = 8'h08;
    localparam logic [7:0] STAT_OFS = 8'h0c;

    localparam logic [3:0] WIN_SEL_RST = 4'h2;
    localparam logic [3:0] ERR_INC = 4'h2;
    localparam logic [2:0] FLT_INT_LO = 3'h3;
    localparam logic [2:0] FLT_FIN_LO = 3'h6;
    localparam logic [2:0] FLT_INT_HI = 3'h1;
    localparam logic [2:0] FLT_FIN_HI = 3'h2;
    localparam logic [15:0] LFSR_RST = 16'hace1;
    localparam logic [15:0] LFSR_TAPS = 16'hb400;

    typedef struct packed {
        logic [2:0] refLimit;
        logic [2:0] errMax;
        logic thrSel;
        logic [1:0] impact;
        logic lrtDis;
        logic inhibit;
    } wwd_cfg_t;

    localparam wwd_cfg_t CFG_RST = '{refLimit: 3'h6, errMax: 3'h6, thrSel: 1'b0,
                                     impact: 2'h3, lrtDis: 1'b0, inhibit: 1'b0};

    typedef struct packed {
        logic preregWait;
        logic deepFsSelect;
        logic keySense;
        logic debugPin;
        logic keepAliveWasOn;
    } wwd_pins_t;

    // half a window in 0.5 ms ticks equals the period in ms
    function automatic logic [10:0] wwd_half_ticks(input logic [3:0] sel);
        unique case (sel)
            4'h0: wwd_half_ticks = 11'd1;
            4'h1: wwd_half_ticks = 11'd2;
            4'h2: wwd_half_ticks = 11'd3;
            4'h3: wwd_half_ticks = 11'd4;
            4'h4: wwd_half_ticks = 11'd6;
            4'h5: wwd_half_ticks = 11'd8;
            4'h6: wwd_half_ticks = 11'd12;
            4'h7: wwd_half_ticks = 11'd16;
            4'h8: wwd_half_ticks = 11'd24;
            4'h9: wwd_half_ticks = 11'd32;
            4'ha: wwd_half_ticks = 11'd64;
            4'hb: wwd_half_ticks = 11'd128;
            4'hc: wwd_half_ticks = 11'd256;
            4'hd: wwd_half_ticks = 11'd512;
            default: wwd_half_ticks = 11'd1024;
        endcase
    endfunction : wwd_half_ticks

endpackage : wwd_pkg

// [hdl/wwd_sync.sv]
// Purpose: two-flop synchroniser for pins from outside the clock domain
// Assumes: inputs are slow levels
// Notes: only the second stage is visible
`timescale 1ns/1ps
module wwd_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rstSync_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] stage1;

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            stage1 <= '0;
            dout <= '0;
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule : wwd_sync

// [hdl/wwd_tick.sv]
// Purpose: 0.5 ms time base from the own oscillator
// Assumes: CYCLES is at least 2
// Notes: clr restarts the prescaler so short windows keep their length
`timescale 1ns/1ps
module wwd_tick #(
    parameter int CYCLES = 62500
) (
    input wire logic clk,
    input wire logic rstSync_n,
    input wire logic clr,
    output logic tick
);
    logic [16:0] cnt;
    wire logic atEnd = (cnt == 17'(CYCLES - 1));

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            cnt <= '0;
            tick <= 1'b0;
        end else begin
            cnt <= (clr || atEnd) ? '0 : cnt + 17'd1;
            tick <= atEnd && !clr;
        end
    end
endmodule : wwd_tick

// [hdl/wwd_top.sv]
// Purpose: windowed watchdog, fault counting and deep fail-safe entry
// Assumes: APB master per the protocol; pins are asynchronous levels
// Notes: all pin outputs are active low where named _n
//
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module wwd_top import wwd_pkg::*; #(
    parameter int TICK_CYCLES = TICK_CYC_DEF
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire wwd_pins_t pinsIn,
    output logic mcuResetLine_n,
    output logic primarySafeOutput_n,
    output logic secondarySafeOutput_n,
    output logic regulatorsOn,
    output logic keepAliveSupplyOn,
    output logic deepFailSafe,
    output logic wakeUp
);

    typedef enum logic [4:0] {
        S_PWR = 5'b00001,
        S_INIT = 5'b00010,
        S_NORM = 5'b00100,
        S_DEEP = 5'b01000,
        S_OFF = 5'b10000
    } wwd_state_t;

    ////////////////////////////////////////////////////////////////////////
    // reset release and pin synchronisation

    logic rstQ1;
    logic rstSync_n;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstQ1 <= 1'b0;
            rstSync_n <= 1'b0;
        end else begin
            rstQ1 <= 1'b1;
            rstSync_n <= rstQ1;
        end
    end

    wwd_pins_t pins;

    wwd_sync #(.W($bits(wwd_pins_t))) u_sync (
        .clk(clk),
        .rstSync_n(rstSync_n),
        .din(pinsIn),
        .dout(pins)
    );

    ////////////////////////////////////////////////////////////////////////
    // state and counters

    wwd_state_t state;
    wwd_cfg_t cfg;
    logic [3:0] winSel;
    logic [10:0] curHalf;
    logic [10:0] halfCnt;
    logic winOpen;
    logic [9:0] initCnt;
    logic [3:0] wdErr;
    logic [2:0] refCnt;
    logic [2:0] faultCnt;
    logic rstLow;
    logic [5:0] rstCnt;
    logic [14:0] lrCnt;
    logic safeLow;
    logic debugMode;
    logic keepAliveHeld;
    logic [15:0] lfsr;
    logic tick;

    ////////////////////////////////////////////////////////////////////////
    // apb decode

    wire logic accPhase = psel && penable && !pready;
    wire logic wrEn = psel && penable && pready && pwrite;
    wire logic hitCfg = (paddr == CFG_OFS);
    wire logic hitWin = (paddr == WIN_OFS);
    wire logic hitRef = (paddr == REF_OFS);
    wire logic hitStat = (paddr == STAT_OFS);
    wire logic mapped = hitCfg || hitWin || hitRef || hitStat;

    wire logic inInit = (state == S_INIT);
    wire logic inNorm = (state == S_NORM);
    wire logic active = inInit || inNorm;

    // init-only configuration locks at the first good refresh
    wire logic wrCfg = wrEn && hitCfg && inInit; // see RULE5 see RULE9
    wire logic wrWin = wrEn && hitWin && active; // see RULE8
    wire logic wrRef = wrEn && hitRef && active; // see RULE12

    wire logic [31:0] statWord = {14'h0, state, debugMode, winOpen, safeLow, rstLow,
                                  faultCnt, refCnt, wdErr[2:0]};
    wire logic [31:0] rdMux = hitCfg ? {21'h0, cfg} :
                              hitWin ? {28'h0, winSel} :
                              hitRef ? {16'h0, lfsr} :
                              hitStat ? statWord : 32'h0;

    ////////////////////////////////////////////////////////////////////////
    // watchdog window events

    wire logic wdRun = active && !cfg.inhibit && !rstLow;
    wire logic halfEnd = tick && (halfCnt == curHalf - 11'd1); // see RULE17
    wire logic initTimeout = inInit && wdRun && tick && (initCnt == INIT_LAST); // see RULE13 see RULE14
    wire logic goodRef = wdRun && wrRef && (inInit || winOpen); // see RULE10 see RULE14
    wire logic badWrite = wdRun && wrRef && inNorm && !winOpen; // see RULE11
    wire logic timeout = wdRun && inNorm && winOpen && halfEnd; // see RULE21
    wire logic wrong = badWrite || timeout;
    wire logic [3:0] errSum = wdErr + ERR_INC; // see RULE18
    wire logic errHit = wrong && (errSum >= {1'b0, cfg.errMax});

    // debug suppresses the pin effect only, counters keep going
    wire logic rstReq = !debugMode && (initTimeout || (errHit && cfg.impact[0])); // see RULE7 see RULE22
    wire logic safeReq = !debugMode && (initTimeout || (errHit && cfg.impact[1])); // see RULE7 see RULE22
    wire logic faultInc = initTimeout || errHit; // see RULE23
    wire logic refAtLimit = (refCnt == cfg.refLimit);
    wire logic faultDec = goodRef && inNorm && refAtLimit && (faultCnt != 3'h0); // see RULE19

    wire logic [2:0] fltInter = cfg.thrSel ? FLT_INT_HI : FLT_INT_LO; // see RULE24
    wire logic [2:0] fltFinal = cfg.thrSel ? FLT_FIN_HI : FLT_FIN_LO; // see RULE24

    ////////////////////////////////////////////////////////////////////////
    // long reset timer and state moves

    wire logic lrRun = rstLow && !cfg.lrtDis && (state != S_PWR || pins.preregWait); // see RULE4 see RULE5
    wire logic lrExpired = (lrCnt == LONG_TICKS);
    wire logic canDeep = pins.deepFsSelect && (state == S_PWR || active);
    wire logic goDeep = canDeep && (lrExpired || (faultCnt >= fltFinal)); // see RULE1
    wire logic pwrRelease = (state == S_PWR) && pins.preregWait && tick && (rstCnt == PWRUP_LAST);
    wire logic rstRelease = active && rstLow && tick && (rstCnt == RSTLOW_LAST);
    wire logic wake = (state == S_OFF) && pins.keySense; // see RULE3
    wire logic tickClr = goodRef || wrong || initTimeout || rstReq || pwrRelease;

    wwd_tick #(.CYCLES(TICK_CYCLES)) u_tick (
        .clk(clk),
        .rstSync_n(rstSync_n),
        .clr(tickClr),
        .tick(tick)
    );

    wwd_state_t next_state;

    always_comb begin
        next_state = state;
        unique case (state)
            S_PWR: begin
                if (goDeep) begin
                    next_state = S_DEEP;
                end else if (pwrRelease) begin
                    next_state = S_INIT;
                end
            end
            S_INIT: begin
                if (goDeep) begin
                    next_state = S_DEEP;
                end else if (goodRef) begin
                    next_state = S_NORM;
                end
            end
            S_NORM: begin
                if (goDeep) begin
                    next_state = S_DEEP;
                end else if (rstReq) begin
                    next_state = S_INIT;
                end
            end
            S_DEEP: begin
                if (!pins.keySense) begin
                    next_state = S_OFF; // see RULE3
                end
            end
            S_OFF: begin
                if (wake) begin
                    next_state = S_PWR;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state <= S_PWR;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers, wiped again at wake-up

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            cfg <= CFG_RST;
            winSel <= WIN_SEL_RST;
        end else if (wake) begin
            cfg <= CFG_RST;
            winSel <= WIN_SEL_RST;
        end else begin
            if (wrCfg) begin
                cfg <= wwd_cfg_t'(pwdata[$bits(wwd_cfg_t)-1:0]);
            end
            if (wrWin) begin
                winSel <= pwdata[3:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // window timing

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            curHalf <= wwd_half_ticks(WIN_SEL_RST); // see RULE25
            halfCnt <= '0;
            winOpen <= 1'b0;
            initCnt <= '0;
        end else if (!wdRun) begin
            halfCnt <= '0;
            winOpen <= 1'b0;
            initCnt <= '0;
            if (wrWin && cfg.inhibit) begin
                curHalf <= wwd_half_ticks(pwdata[3:0]); // see RULE16
            end
        end else if (goodRef || wrong) begin
            // pending period is applied at a window restart; an inhibited watchdog takes a new period at the write
            curHalf <= wwd_half_ticks(winSel); // see RULE15 see RULE16
            halfCnt <= '0;
            winOpen <= 1'b0; // see RULE10 see RULE11
        end else if (inInit) begin
            initCnt <= tick ? initCnt + 10'd1 : initCnt;
        end else if (halfEnd) begin
            halfCnt <= '0;
            winOpen <= 1'b1; // see RULE21
        end else if (tick) begin
            halfCnt <= halfCnt + 11'd1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // error, refresh and fault counters

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            wdErr <= '0;
            refCnt <= '0;
            faultCnt <= '0;
        end else if (wake) begin
            wdErr <= '0;
            refCnt <= '0;
            faultCnt <= '0;
        end else begin
            if (errHit) begin
                wdErr <= '0;
            end else if (wrong) begin
                wdErr <= errSum; // see RULE18
            end else if (goodRef && wdErr != 4'h0) begin
                wdErr <= wdErr - 4'h1; // see RULE18
            end
            if (wrong) begin
                refCnt <= '0; // see RULE20
            end else if (goodRef) begin
                refCnt <= refAtLimit ? 3'h0 : refCnt + 3'h1; // see RULE19
            end
            if (faultInc && faultCnt != FLT_FIN_LO) begin
                faultCnt <= faultCnt + 3'h1; // see RULE23
            end else if (faultDec && !faultInc) begin
                faultCnt <= faultCnt - 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reset line, safe output, long reset timer

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            rstLow <= 1'b1;
            rstCnt <= '0;
            lrCnt <= '0;
            safeLow <= 1'b0;
        end else if (wake) begin
            rstLow <= 1'b1;
            rstCnt <= '0;
            lrCnt <= '0;
            safeLow <= 1'b0;
        end else begin
            if (rstReq) begin
                rstLow <= 1'b1;
                rstCnt <= '0;
                lrCnt <= '0; // see RULE6
            end else if (pwrRelease || rstRelease) begin
                rstLow <= 1'b0; // see RULE4
                rstCnt <= '0;
            end else if (tick && rstLow && (state == S_PWR ? pins.preregWait : active)) begin
                rstCnt <= rstCnt + 6'h1;
            end
            if (!rstLow || rstReq) begin
                lrCnt <= '0;
            end else if (lrRun && tick && !lrExpired) begin
                lrCnt <= lrCnt + 15'h1; // see RULE25
            end
            if (safeReq || (faultCnt >= fltInter && !debugMode)) begin
                safeLow <= 1'b1; // see RULE22 see RULE24
            end else if (faultCnt == 3'h0) begin
                safeLow <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // start-up strap, lfsr, pins and bus answer

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            debugMode <= 1'b0;
            keepAliveHeld <= 1'b0;
            lfsr <= LFSR_RST;
        end else begin
            if (pwrRelease) begin
                debugMode <= pins.debugPin; // see RULE7
                keepAliveHeld <= pins.keepAliveWasOn;
            end
            // refresh reads return the lfsr; written refresh content is never checked
            lfsr <= (lfsr >> 1) ^ (lfsr[0] ? LFSR_TAPS : 16'h0000); // see RULE12
        end
    end

    wire logic inDeep = (state == S_DEEP) || (state == S_OFF);

    always_ff @(posedge clk or negedge rstSync_n) begin
        if (!rstSync_n) begin
            mcuResetLine_n <= 1'b0;
            primarySafeOutput_n <= 1'b0;
            secondarySafeOutput_n <= 1'b0;
            regulatorsOn <= 1'b0;
            keepAliveSupplyOn <= 1'b0;
            deepFailSafe <= 1'b0;
            wakeUp <= 1'b0;
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            mcuResetLine_n <= !(rstLow || inDeep); // see RULE2
            primarySafeOutput_n <= !(safeLow || inDeep); // see RULE2
            secondarySafeOutput_n <= !(safeLow || inDeep);
            regulatorsOn <= !inDeep; // see RULE2
            keepAliveSupplyOn <= inDeep ? keepAliveHeld : 1'b1;
            deepFailSafe <= (state == S_DEEP);
            wakeUp <= wake; // see RULE3
            prdata <= (accPhase && !pwrite) ? rdMux : 32'h0;
            pready <= accPhase;
            pslverr <= accPhase && !mapped;
        end
    end

endmodule : wwd_top

// [test/wwd_top_chk.sv]
// Purpose: port-level checks of the watchdog top
// Assumes: TICK_CYCLES equals that of the instance
// Notes: bound into every wwd_top
`timescale 1ns/1ps
module wwd_top_chk import wwd_pkg::*; #(
    parameter int TICK_CYCLES = TICK_CYC_DEF
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire wwd_pins_t pinsIn,
    input wire logic mcuResetLine_n,
    input wire logic primarySafeOutput_n,
    input wire logic secondarySafeOutput_n,
    input wire logic regulatorsOn,
    input wire logic deepFailSafe,
    input wire logic wakeUp
);
    logic [15:0] lowCnt;
    logic [15:0] upCnt;
    // saturating, so a long deep stay cannot wrap into a false failure
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lowCnt <= '0;
            upCnt <= '0;
        end else begin
            lowCnt <= mcuResetLine_n ? '0 : lowCnt + {15'h0, ~&lowCnt};
            upCnt <= wakeUp ? '0 : upCnt + {15'h0, ~&upCnt};
        end
    end
    ////////////////////////////////////////
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence sSetup;
        psel && !penable;
    endsequence
    sequence sAccess;
        psel && penable && !pready;
    endsequence
    chk_one_wait: assert property (sSetup ##1 sAccess |=> pready)
        else $error("no answer after one wait state");
    chk_err_unmapped: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error answer malformed");
    chk_pwrup_hold: assert property (mcuResetLine_n |-> upCnt >= 16'(32 * TICK_CYCLES))
        else $error("reset line released too early");
    chk_rst_pulse: assert property ($rose(mcuResetLine_n) |-> lowCnt >= 16'(19 * TICK_CYCLES))
        else $error("reset pulse too short");
    chk_deep_outs: assert property (deepFailSafe && $past(deepFailSafe) |->
        !mcuResetLine_n && !primarySafeOutput_n && !regulatorsOn)
        else $error("deep state outputs wrong");
    chk_safe_pair: assert property (secondarySafeOutput_n == primarySafeOutput_n)
        else $error("safe outputs differ");
    chk_deep_enable: assert property ($rose(deepFailSafe) |-> pinsIn.deepFsSelect)
        else $error("deep state while disabled");
    chk_key_off: assert property ((deepFailSafe && !pinsIn.keySense) [*6] |=> !deepFailSafe)
        else $error("key off ignored");
    chk_wake_once: assert property (wakeUp |-> !$past(regulatorsOn) ##1 !wakeUp)
        else $error("wake pulse wrong");
endmodule : wwd_top_chk
bind wwd_top wwd_top_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clk, .rst_n, .psel, .penable, .prdata, .pready,
    .pslverr, .pinsIn, .mcuResetLine_n, .primarySafeOutput_n, .secondarySafeOutput_n, .regulatorsOn,
    .deepFailSafe, .wakeUp);

// [test/wwd_host.sv]
// Purpose: host controller model doing register accesses
// Assumes: xfer is entered just after a rising edge
// Notes: one transfer at a time
`timescale 1ns/1ps
module wwd_host (
    input wire logic clk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
        output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge: back-to-back calls never drive a strobe twice at once
        @(posedge clk);
    endtask : xfer
endmodule : wwd_host

// [test/wwd_top_tb.sv]
// Purpose: self-checking bench of the watchdog top
// Assumes: tick shortened to TK clocks
// Notes: refresh data, window and keep-alive level from a seeded xorshift
`timescale 1ns/1ps
module wwd_top_tb import wwd_pkg::*;;
    localparam int TK = 10;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    wwd_pins_t pinsIn = 5'h1c;
    logic mcuResetLine_n;
    logic primarySafeOutput_n;
    logic secondarySafeOutput_n;
    logic regulatorsOn;
    logic keepAliveSupplyOn;
    logic deepFailSafe;
    logic wakeUp;
    logic [31:0] seed = 32'hcec282fd;
    logic [31:0] q;
    logic e;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;
    int tRef = 0;
    int h = 3;
    int i;
    int n;
    always #4 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    wwd_top #(.TICK_CYCLES(TK)) DUT (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .pinsIn, .mcuResetLine_n, .primarySafeOutput_n, .secondarySafeOutput_n, .regulatorsOn,
        .keepAliveSupplyOn, .deepFailSafe, .wakeUp);
    wwd_host host (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
    ////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        host.xfer(w, a, d, q, e);
    endtask : acc
    task automatic stat(input logic [31:0] m, input logic [31:0] x);
        acc(1'b0, STAT_OFS, 32'h0);
        chk(q & m, x);
    endtask : stat
    task automatic waitRel();
        for (int k = 0; k < 3000 && mcuResetLine_n !== 1'b1; k++) @(posedge clk);
        chk(mcuResetLine_n, 1'b1);
    endtask : waitRel
    // aim at the middle of the open half
    task automatic good();
        while (cyc < tRef + 3 * h * TK / 2 - 4) @(posedge clk);
        acc(1'b1, REF_OFS, rnd());
        tRef = cyc;
    endtask : good
    task automatic conclude();
        $display("counts: %0d compares, %0d mismatches", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude
    ////////////////////////////////////////
    initial begin
        n = rnd();
        pinsIn.keepAliveWasOn <= seed[0];
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        acc(1'b0, CFG_OFS, 32'h0);
        chk(q, 32'h6cc);
        acc(1'b0, WIN_OFS, 32'h0);
        chk(q, 32'h2);
        acc(1'b0, 8'h10, 32'h0);
        chk({q[30:0], e}, 32'h1);
        waitRel();
        $display("test power-up done");
        for (i = 0; i < 15; i++) begin
            acc(1'b1, WIN_OFS, 32'(i));
            acc(1'b0, WIN_OFS, 32'h0);
            chk(q, 32'(i));
        end
        n = 1 + rnd() % 3;
        acc(1'b1, WIN_OFS, 32'(n));
        h = n + 1;
        // refresh limit 2, error max 4, thresholds 1 and 2, both impacts
        acc(1'b1, CFG_OFS, 32'h29c);
        acc(1'b1, REF_OFS, rnd());
        stat(32'h3e000, 32'h8000);
        acc(1'b1, CFG_OFS, 32'h0);
        acc(1'b0, CFG_OFS, 32'h0);
        chk(q, 32'h29c);
        acc(1'b1, REF_OFS, rnd());
        tRef = cyc;
        stat(32'h3f, 32'h2);
        for (i = 0; i < 4; i++) begin
            good();
            stat(32'h3f, 32'((i < 2 ? 1 - i : 0) + ((i + 1) % 3) * 8));
        end
        $display("test refresh done");
        acc(1'b1, REF_OFS, rnd());
        acc(1'b1, REF_OFS, rnd());
        stat(32'h1c0, 32'h40);
        chk({mcuResetLine_n, primarySafeOutput_n}, 2'b00);
        waitRel();
        chk(primarySafeOutput_n, 1'b0);
        acc(1'b1, REF_OFS, rnd());
        acc(1'b1, REF_OFS, rnd());
        tRef = cyc;
        for (i = 0; i < 3; i++)
            good();
        stat(32'h1f8, 32'h0);
        chk(primarySafeOutput_n, 1'b1);
        $display("test fault counting done");
        while (cyc < tRef + 4 * h * TK + 20) @(posedge clk);
        chk(mcuResetLine_n, 1'b0);
        for (i = 0; i < 9000 && deepFailSafe !== 1'b1; i++) @(posedge clk);
        chk({deepFailSafe, regulatorsOn, keepAliveSupplyOn}, {2'b10, pinsIn.keepAliveWasOn});
        stat(32'h3e000, 32'h10000);
        pinsIn.keySense <= 1'b0;
        repeat (10) @(posedge clk);
        stat(32'h3e000, 32'h20000);
        pinsIn.keySense <= 1'b1;
        pinsIn.debugPin <= 1'b1;
        n = 0;
        repeat (20) begin
            @(posedge clk);
            n += int'(wakeUp === 1'b1);
        end
        chk(32'(n), 32'h1);
        waitRel();
        acc(1'b0, CFG_OFS, 32'h0);
        chk(q, 32'h6cc);
        stat(32'h3f1c7, 32'h5000);
        $display("test deep state done");
        acc(1'b1, REF_OFS, rnd());
        for (i = 0; i < 3; i++) begin
            acc(1'b1, REF_OFS, rnd());
            stat(32'h1c7, i < 2 ? 32'(2 * i + 2) : 32'h40);
        end
        chk({mcuResetLine_n, primarySafeOutput_n}, 2'b11);
        $display("test debug done");
        conclude();
    end
    // the tests need well under 10000 cycles
    initial begin
        repeat (30000) @(posedge clk);
        fails++;
        conclude();
    end
endmodule : wwd_top_tb
